/* File: bench/slc_link_sva.sv */
// checker for the register port and the link controls of the device end
// assumes: instantiated beside the link interface, single aclk domain
`timescale 1ns/100ps
`default_nettype none
`include "slc_cfg.svh"
module slc_link_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [`SLC_ADDR_W-1:0] reg_addr,
  input wire logic [`SLC_DATA_W-1:0] reg_wdata,
  input wire logic link_block_reset,
  input wire logic link_clk_en,
  input wire logic [7:0] lane_enable_a,
  input wire logic [7:0] lane_enable_b,
  input wire logic multiframe_boundary,
  input wire logic scramble_active,
  input wire logic sample_format,
  input wire logic sync_request_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // derived outputs land two edges after the request
  property p_off_quiet;
    link_block_reset |-> !link_clk_en && lane_enable_a == 8'h00 && lane_enable_b == 8'h00;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("lanes or clocks on while disabled");
  property p_enable_wr;
    reg_req && reg_we && reg_addr == `SLC_OFF_LINK_EN && reg_wdata[0] |-> ##2 !link_block_reset && link_clk_en;
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("enable write not applied");
  property p_disable_wr;
    reg_req && reg_we && reg_addr == `SLC_OFF_LINK_EN && !reg_wdata[0] |-> ##2 link_block_reset;
  endproperty
  a_disable_wr: assert property (p_disable_wr) else $error("disable write not applied");
  property p_lane_map;
    !link_block_reset |-> lane_enable_a == lane_enable_b && (lane_enable_a == 8'h0F || lane_enable_a == 8'hF0);
  endproperty
  a_lane_map: assert property (p_lane_map) else $error("lane enables not a legal mapping");
  property p_soft_sync;
    reg_req && reg_we && reg_addr == `SLC_OFF_SYNC && !reg_wdata[0] |-> ##2 !sync_request_n;
  endproperty
  a_soft_sync: assert property (p_soft_sync) else $error("soft request not raised");
  property p_format;
    reg_req && reg_we && reg_addr == `SLC_OFF_CTRL |-> ##2 sample_format == $past(reg_wdata[1], 2);
  endproperty
  a_format: assert property (p_format) else $error("sample format not taken");
  property p_scr_on;
    reg_req && reg_we && reg_addr == `SLC_OFF_CTRL && reg_wdata[0] |-> ##2 scramble_active;
  endproperty
  a_scr_on: assert property (p_scr_on) else $error("scrambler off with bit set");
  // counter may still finish a frame in the first disabled cycle
  property p_no_boundary;
    link_block_reset ##1 link_block_reset |=> !multiframe_boundary;
  endproperty
  a_no_boundary: assert property (p_no_boundary) else $error("boundary while disabled");
endmodule
`default_nettype wire

/* File: bench/tb_serial_link_config_regs.sv */
// bench: axi master, reference model of both ends, output comparison
// assumes: design files and inc/ on the include path
`timescale 1ns/100ps
`default_nettype none
`include "slc_cfg.svh"
module tb_serial_link_config_regs;
  logic aclk = 0, aresetn = 0, ded = 1, ts = 1, frame_strobe = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, s_axi_rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic link_block_reset, link_clk_en, multiframe_boundary, scramble_active, sample_format;
  logic sync_request_n, timestamp_receiver_enable;
  logic [7:0] lane_enable_a, lane_enable_b;
  logic [10:0] frames_per_multiframe;
  logic [4:0] link_test_select;
  logic [15:0] lfsr = 16'h0242;
  logic [31:0] st;
  logic [1:0] rsp;
  int num_errors = 0, comparisons = 0, m[6], tse = 0, mf_seen = 0;
  logic prev_strobe = 0, prev_rstn = 0;
  slc_link_if link_if();
  slc_device i_slc_device (.aclk(aclk), .aresetn(aresetn), .link(link_if),
    .dedicated_sync_input(ded), .timestamp_input(ts), .frame_strobe(frame_strobe),
    .link_block_reset(link_block_reset), .link_clk_en(link_clk_en),
    .lane_enable_a(lane_enable_a), .lane_enable_b(lane_enable_b),
    .frames_per_multiframe(frames_per_multiframe), .multiframe_boundary(multiframe_boundary),
    .scramble_active(scramble_active), .sample_format(sample_format),
    .sync_request_n(sync_request_n), .link_test_select(link_test_select));
  slc_host i_slc_host (.aclk(aclk), .aresetn(aresetn), .link(link_if),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(rready), .timestamp_receiver_enable(timestamp_receiver_enable));
  slc_link_sva i_slc_link_sva (.aclk(aclk), .aresetn(aresetn), .reg_req(link_if.reg_req),
    .reg_we(link_if.reg_we), .reg_addr(link_if.reg_addr), .reg_wdata(link_if.reg_wdata),
    .link_block_reset(link_block_reset), .link_clk_en(link_clk_en),
    .lane_enable_a(lane_enable_a), .lane_enable_b(lane_enable_b),
    .multiframe_boundary(multiframe_boundary), .scramble_active(scramble_active),
    .sample_format(sample_format), .sync_request_n(sync_request_n));
  always #2.5 aclk = ~aclk;
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // strobes land at random so the multiframe counter runs unevenly
  always @(posedge aclk)
  begin
    lfsr <= lfsr_next(lfsr);
    frame_strobe <= lfsr[0];
  end
  // strobes counted one edge late to line up with the enable and the pulse
  always @(posedge aclk)
  begin
    if (!prev_rstn || !link_clk_en)
      mf_seen = 0;
    else if (prev_strobe)
      mf_seen++;
    if (multiframe_boundary)
    begin
      chk(mf_seen, frames_per_multiframe);
      mf_seen = 0;
    end
    prev_strobe <= frame_strobe;
    prev_rstn <= aresetn;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1;
    w = 1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (aw || w)
    begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin aw = 0; awvalid <= 0; end
      if (w && s_axi_wready) begin w = 0; wvalid <= 0; end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    rsp = s_axi_bresp;
    bready <= 0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    st = s_axi_rdata;
    rsp = s_axi_rresp;
    rready <= 0;
  endtask
  // command, then poll status until done
  task automatic dev_acc(input int o, input int v, input int cmd);
    axi_wr(`SLC_AXI_OFF_ADDR, 32'h200 + o);
    axi_wr(`SLC_AXI_OFF_WDATA, v);
    axi_wr(`SLC_AXI_OFF_CMD, cmd);
    repeat (3) @(posedge aclk);
    do axi_rd(`SLC_AXI_OFF_STATUS); while (st[0] || !st[1]);
  endtask
  task automatic chk_out;
    int md, e, f, k, la, sel, pin;
    md = m[1];
    e = (md & 3) + 1;
    f = 1 << ((md >> 2) & 3);
    k = (md & 64) ? 256 * e / f : m[2] + 1;
    la = !(m[0] & 1) ? 0 : (m[4] & 16) ? 8'hF0 : 8'h0F;
    sel = (m[4] >> 2) & 3;
    pin = sel == 0 ? ded : sel == 1 ? ts : 1;
    chk(link_block_reset, !(m[0] & 1));
    chk(link_clk_en, m[0] & 1);
    chk(lane_enable_a, la);
    chk(lane_enable_b, la);
    chk(frames_per_multiframe, k);
    chk(scramble_active, ((md >> 6) | m[4]) & 1);
    chk(sample_format, (m[4] >> 1) & 1);
    chk(sync_request_n, m[3] & pin & 1);
    chk(timestamp_receiver_enable, tse);
    chk(link_test_select, m[5] & 31);
  endtask
  task automatic dev_wr(input int o, input int v);
    logic rf;
    rf = ((o == 2 || o == 4) && (m[0] & 1)) || (o == 4 && (v & 16) && (4 << ((m[1] >> 4) & 3)) > 8);
    dev_acc(o, v, 1);
    chk(st[2], rf);
    if (!rf) m[o] = v & 8'hFF;
    if (!rf && o == 4) tse = ((v >> 2) & 3) == 1;
    repeat (3) @(posedge aclk);
    chk_out;
  endtask
  task automatic dev_rd(input int o);
    dev_acc(o, 0, 2);
    chk(st[15:8], o < 6 ? m[o] : 0);
    chk(rsp, `SLC_RESP_OKAY);
  endtask
  initial
  begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    complete_run;
  end
  initial
  begin
    m = '{8'h01, 8'h02, 8'h1F, 8'h01, 8'h03, 8'h00};
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 7; i++) dev_rd(i);
    chk_out;
    axi_wr(4'h2, 0);
    chk(rsp, `SLC_RESP_SLVERR);
    axi_rd(4'h2);
    chk(rsp, `SLC_RESP_SLVERR);
    chk(st, 0);
    dev_wr(2, 8'h05);
    dev_wr(0, 0);
    foreach (m[i]) if (i != 0 && i != 3) dev_wr(i, i == 4 ? 8'h00 : 8'hA0);
    for (int i = 0; i < 3; i++)
    begin
      dev_wr(2, i == 0 ? 8'h00 : i == 1 ? 8'hFF : lfsr[7:0]);
      dev_wr(0, 1);
      dev_wr(0, 0);
    end
    for (int i = 0; i < 4; i++)
    begin
      dev_wr(1, 8'h40 | ((lfsr % 3) << 4) | lfsr[3:0]);
      dev_wr(4, (lfsr[1] << 1) | 16);
      dev_wr(0, 1);
      dev_wr(0, 0);
    end
    dev_wr(1, 8'h22);
    dev_wr(4, 8'h13);
    dev_wr(1, 8'h02);
    // short multiframes so boundaries fall inside each enabled stretch
    dev_wr(2, 8'h03);
    for (int s = 0; s < 3; s++)
      for (int j = 0; j < 4; j++)
      begin
        ded <= j[0];
        ts <= j[1];
        dev_wr(4, (s << 2) | (j[0] << 4) | 3);
        dev_wr(0, 1);
        dev_wr(3, 0);
        dev_wr(3, 1);
        dev_wr(0, 0);
      end
    dev_wr(5, lfsr[7:0]);
    dev_rd(5);
    axi_rd(`SLC_AXI_OFF_ADDR);
    chk(st, 32'h205);
    complete_run;
  end
endmodule
`default_nettype wire

/* File: inc/slc_cfg.svh */
// constants for the serial link configuration registers and their controller
// assumes: included by bare name from the package and both ends
// What this block does
// - multiframe length register holds frames minus one
// - 64b/66b modes derive frames from mode
// - host changes length, scrambler only when disabled
// - writing zero to soft sync requests sync
// - soft sync works under any source selection
// - low pin holds request unless no pin
// - lane bit zero uses lanes zero to three
// - lane bit one uses lanes four to seven
// - host refuses a control write picking upper lanes when mode has over eight lanes
// - sync source field picks pin, timestamp, none
// - timestamp source needs timestamp receiver enabled
// - format bit picks offset binary or twos complement
// - scrambler bit controls 8b/10b scrambling
// - 64b/66b modes always scramble
// - link disabled holds block, lanes, counter off
`ifndef SLC_CFG_SVH
`define SLC_CFG_SVH
`define SLC_ADDR_W 12
`define SLC_DATA_W 8
`define SLC_OFF_LINK_EN 12'h200
`define SLC_OFF_MODE 12'h201
`define SLC_OFF_FRAMES 12'h202
`define SLC_OFF_SYNC 12'h203
`define SLC_OFF_CTRL 12'h204
`define SLC_OFF_TEST 12'h205
`define SLC_RST_LINK_EN 8'h01
`define SLC_RST_MODE 8'h02
`define SLC_RST_FRAMES 8'h1F
`define SLC_RST_SYNC 8'h01
`define SLC_RST_CTRL 8'h03
`define SLC_RST_TEST 8'h00
`define SLC_BIT_LINK_EN 0
`define SLC_BIT_SOFT_SYNC 0
`define SLC_BIT_SCRAMBLE 0
`define SLC_BIT_FMT 1
`define SLC_SYNC_SEL_LO 2
`define SLC_SYNC_SEL_HI 3
`define SLC_BIT_UPPER 4
`define SLC_TEST_W 5
`define SLC_K_W 11
`define SLC_K_6466_SCALE 11'h100
`define SLC_LANES_LOWER 8'h0F
`define SLC_LANES_UPPER 8'hF0
`define SLC_UPPER_LANE_LIMIT 6'h08
`define SLC_AXI_ADDR_W 4
`define SLC_AXI_OFF_ADDR 4'h0
`define SLC_AXI_OFF_WDATA 4'h4
`define SLC_AXI_OFF_CMD 4'h8
`define SLC_AXI_OFF_STATUS 4'hC
`define SLC_CMD_WRITE 0
`define SLC_CMD_READ 1
`define SLC_ST_BUSY 0
`define SLC_ST_DONE 1
`define SLC_ST_REFUSED 2
`define SLC_ST_TS_RX 3
`define SLC_ST_RDATA_LO 8
`define SLC_RESP_OKAY 2'h0
`define SLC_RESP_SLVERR 2'h2
`endif

/* File: inc/slc_link_if.sv */
// register port between the configuration controller and the device
// assumes: one clock shared by both ends
`timescale 1ns/100ps
`default_nettype none
`include "slc_cfg.svh"
interface slc_link_if;
  logic reg_req;
  logic reg_we;
  logic [`SLC_ADDR_W-1:0] reg_addr;
  logic [`SLC_DATA_W-1:0] reg_wdata;
  logic reg_ack;
  logic [`SLC_DATA_W-1:0] reg_rdata;
  modport dev (
    input reg_req,
    input reg_we,
    input reg_addr,
    input reg_wdata,
    output reg_ack,
    output reg_rdata
  );
  modport ctl (
    output reg_req,
    output reg_we,
    output reg_addr,
    output reg_wdata,
    input reg_ack,
    input reg_rdata
  );
endinterface
`default_nettype wire

/* File: inc/slc_pkg.sv */
// types shared by the link configuration device and its controller
// assumes: slc_cfg.svh on the include path
`include "slc_cfg.svh"
package slc_pkg;
  typedef enum logic [1:0] {
    SLC_SYNC_DEDICATED = 2'h0,
    SLC_SYNC_TIMESTAMP = 2'h1,
    SLC_SYNC_NONE = 2'h2,
    SLC_SYNC_RSVD = 2'h3
  } slc_sync_sel_type;

  typedef struct packed {
    logic is_6466;
    logic [2:0] e;
    logic [3:0] f;
    // six bits so that a count of 32 lanes does not wrap to zero
    logic [5:0] lanes;
  } slc_mode_info_type;

  // mode decode: bit6 encoding, [5:4] lane count, [3:2] F, [1:0] E
  function automatic slc_mode_info_type slc_decode_mode(input logic [7:0] mode);
    slc_mode_info_type m;
    m.is_6466 = mode[6];
    m.e = {1'b0, mode[1:0]} + 3'h1;
    m.f = 4'h1 << mode[3:2];
    m.lanes = 6'h04 << mode[5:4];
    return m;
  endfunction
endpackage

/* File: rtl/slc_device.sv */
// device end: link configuration registers and the link controls they steer
// assumes: controller pulses reg_req for one cycle; sync pins synchronous to aclk
`timescale 1ns/100ps
`default_nettype none
`include "slc_cfg.svh"
module slc_device (
  input wire logic aclk,
  input wire logic aresetn,
  slc_link_if.dev link,
  input wire logic dedicated_sync_input,
  input wire logic timestamp_input,
  input wire logic frame_strobe,
  output logic link_block_reset,
  output logic link_clk_en,
  output logic [7:0] lane_enable_a,
  output logic [7:0] lane_enable_b,
  output logic [`SLC_K_W-1:0] frames_per_multiframe,
  output logic multiframe_boundary,
  output logic scramble_active,
  output logic sample_format,
  output logic sync_request_n,
  output logic [`SLC_TEST_W-1:0] link_test_select
);
  logic [7:0] link_enable_q, link_enable_d;
  logic [7:0] link_mode_select_q, link_mode_select_d;
  logic [7:0] frames_per_multiframe_minus_one_q, frames_per_multiframe_minus_one_d;
  logic [7:0] soft_sync_request_n_q, soft_sync_request_n_d;
  logic [7:0] link_control_q, link_control_d;
  logic [7:0] link_test_q, link_test_d;
  logic ack_q, ack_d;
  logic [7:0] rdata_q, rdata_d;
  logic blk_rst_q, blk_rst_d;
  logic clk_en_q, clk_en_d;
  logic [7:0] lane_q, lane_d;
  logic [`SLC_K_W-1:0] k_q, k_d;
  logic scramble_q, scramble_d;
  logic fmt_q, fmt_d;
  logic sync_n_q, sync_n_d;
  logic [`SLC_K_W-1:0] mf_cnt_q, mf_cnt_d;
  logic mf_pulse_q, mf_pulse_d;
  slc_pkg::slc_mode_info_type mode_info;
  slc_pkg::slc_sync_sel_type sync_sel;
  logic pin_level;
  logic en;

  // unmapped offsets read as zero
  function automatic logic [7:0] read_mux(input logic [`SLC_ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `SLC_OFF_LINK_EN)
      v = link_enable_q;
    else if (a == `SLC_OFF_MODE)
      v = link_mode_select_q;
    else if (a == `SLC_OFF_FRAMES)
      v = frames_per_multiframe_minus_one_q;
    else if (a == `SLC_OFF_SYNC)
      v = soft_sync_request_n_q;
    else if (a == `SLC_OFF_CTRL)
      v = link_control_q;
    else if (a == `SLC_OFF_TEST)
      v = link_test_q;
    return v;
  endfunction

  // register file
  always_comb
  begin
    link_enable_d = link_enable_q;
    link_mode_select_d = link_mode_select_q;
    frames_per_multiframe_minus_one_d = frames_per_multiframe_minus_one_q;
    soft_sync_request_n_d = soft_sync_request_n_q;
    link_control_d = link_control_q;
    link_test_d = link_test_q;
    ack_d = link.reg_req;
    rdata_d = rdata_q;
    if (link.reg_req && link.reg_we)
    begin
      if (link.reg_addr == `SLC_OFF_LINK_EN)
        link_enable_d = link.reg_wdata;
      else if (link.reg_addr == `SLC_OFF_MODE)
        link_mode_select_d = link.reg_wdata;
      else if (link.reg_addr == `SLC_OFF_FRAMES)
        frames_per_multiframe_minus_one_d = link.reg_wdata;
      else if (link.reg_addr == `SLC_OFF_SYNC)
        soft_sync_request_n_d = link.reg_wdata;
      else if (link.reg_addr == `SLC_OFF_CTRL)
        link_control_d = link.reg_wdata;
      else if (link.reg_addr == `SLC_OFF_TEST)
        link_test_d = link.reg_wdata;
    end
    else if (link.reg_req)
      rdata_d = read_mux(link.reg_addr);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link_enable_q <= `SLC_RST_LINK_EN;
      link_mode_select_q <= `SLC_RST_MODE;
      frames_per_multiframe_minus_one_q <= `SLC_RST_FRAMES;
      soft_sync_request_n_q <= `SLC_RST_SYNC;
      link_control_q <= `SLC_RST_CTRL;
      link_test_q <= `SLC_RST_TEST;
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end
    else
    begin
      link_enable_q <= link_enable_d;
      link_mode_select_q <= link_mode_select_d;
      frames_per_multiframe_minus_one_q <= frames_per_multiframe_minus_one_d;
      soft_sync_request_n_q <= soft_sync_request_n_d;
      link_control_q <= link_control_d;
      link_test_q <= link_test_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // link controls derived from the registers
  always_comb
  begin
    mode_info = slc_pkg::slc_decode_mode(link_mode_select_q);
    sync_sel = slc_pkg::slc_sync_sel_type'(
      link_control_q[`SLC_SYNC_SEL_HI:`SLC_SYNC_SEL_LO]);
    en = link_enable_q[`SLC_BIT_LINK_EN];
    case (sync_sel)
      slc_pkg::SLC_SYNC_DEDICATED: pin_level = dedicated_sync_input;
      slc_pkg::SLC_SYNC_TIMESTAMP: pin_level = timestamp_input;
      // reserved code behaves as no pin
      default: pin_level = 1'b1;
    endcase
    // soft bit and pin combine regardless of selection
    sync_n_d = soft_sync_request_n_q[`SLC_BIT_SOFT_SYNC] & pin_level;
    blk_rst_d = !en;
    clk_en_d = en;
    if (!en)
      lane_d = 8'h00;
    else if (link_control_q[`SLC_BIT_UPPER])
      lane_d = `SLC_LANES_UPPER;
    else
      lane_d = `SLC_LANES_LOWER;
    // 64b/66b: register ignored, K from mode; 8b/10b: K is register plus one
    if (mode_info.is_6466)
      k_d = (`SLC_K_6466_SCALE * {8'h00, mode_info.e}) / {7'h00, mode_info.f};
    else
      k_d = {3'h0, frames_per_multiframe_minus_one_q} + 11'h001;
    scramble_d = mode_info.is_6466 | link_control_q[`SLC_BIT_SCRAMBLE];
    fmt_d = link_control_q[`SLC_BIT_FMT];
  end

  // multiframe counter, held at zero while disabled
  always_comb
  begin
    mf_cnt_d = mf_cnt_q;
    mf_pulse_d = 1'b0;
    if (!en)
      mf_cnt_d = 11'h000;
    else if (frame_strobe)
    begin
      if (mf_cnt_q >= k_q - 11'h001)
      begin
        mf_cnt_d = 11'h000;
        mf_pulse_d = 1'b1;
      end
      else
        mf_cnt_d = mf_cnt_q + 11'h001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      blk_rst_q <= 1'b0;
      clk_en_q <= 1'b1;
      lane_q <= `SLC_LANES_LOWER;
      k_q <= 11'h020;
      scramble_q <= 1'b1;
      fmt_q <= 1'b1;
      sync_n_q <= 1'b1;
      mf_cnt_q <= 11'h000;
      mf_pulse_q <= 1'b0;
    end
    else
    begin
      blk_rst_q <= blk_rst_d;
      clk_en_q <= clk_en_d;
      lane_q <= lane_d;
      k_q <= k_d;
      scramble_q <= scramble_d;
      fmt_q <= fmt_d;
      sync_n_q <= sync_n_d;
      mf_cnt_q <= mf_cnt_d;
      mf_pulse_q <= mf_pulse_d;
    end
  end

  assign link.reg_ack = ack_q;
  assign link.reg_rdata = rdata_q;
  assign link_block_reset = blk_rst_q;
  assign link_clk_en = clk_en_q;
  // both links share one mapping
  assign lane_enable_a = lane_q;
  assign lane_enable_b = lane_q;
  assign frames_per_multiframe = k_q;
  assign multiframe_boundary = mf_pulse_q;
  assign scramble_active = scramble_q;
  assign sample_format = fmt_q;
  assign sync_request_n = sync_n_q;
  assign link_test_select = link_test_q[`SLC_TEST_W-1:0];
endmodule
`default_nettype wire

/* File: rtl/slc_host.sv */
// controller end: axi4-lite slave that issues register accesses to the device
// assumes: device answers every request with reg_ack
`timescale 1ns/100ps
`default_nettype none
`include "slc_cfg.svh"
module slc_host (
  input wire logic aclk,
  input wire logic aresetn,
  slc_link_if.ctl link,
  input wire logic [`SLC_AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SLC_AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic timestamp_receiver_enable
);
  typedef enum logic [1:0] {
    SLC_H_IDLE = 2'b00,
    SLC_H_REQ = 2'b01,
    SLC_H_WAIT = 2'b10
  } slc_host_state_type;

  slc_host_state_type st_q, st_d;
  logic [3:0] aw_q, aw_d;
  logic aw_ok_q, aw_ok_d;
  logic [31:0] wd_q, wd_d;
  logic w_ok_q, w_ok_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [11:0] addr_q, addr_d;
  logic [7:0] wdat_q, wdat_d;
  logic we_q, we_d;
  logic done_q, done_d;
  logic refused_q, refused_d;
  logic [7:0] rd_q, rd_d;
  logic shadow_en_q, shadow_en_d;
  logic [7:0] shadow_mode_q, shadow_mode_d;
  logic ts_q, ts_d;
  logic wr_fire, start, start_we, guard_bad;
  slc_pkg::slc_mode_info_type mi;

  always_comb
  begin
    st_d = st_q;
    aw_d = aw_q;
    aw_ok_d = aw_ok_q;
    wd_d = wd_q;
    w_ok_d = w_ok_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    we_d = we_q;
    done_d = done_q;
    refused_d = refused_q;
    rd_d = rd_q;
    shadow_en_d = shadow_en_q;
    shadow_mode_d = shadow_mode_q;
    ts_d = ts_q;
    start = 1'b0;
    start_we = 1'b0;
    mi = slc_pkg::slc_decode_mode(shadow_mode_q);
    if (s_axi_awvalid && !aw_ok_q)
    begin
      aw_d = s_axi_awaddr;
      aw_ok_d = 1'b1;
    end
    if (s_axi_wvalid && !w_ok_q)
    begin
      wd_d = s_axi_wdata;
      w_ok_d = 1'b1;
    end
    wr_fire = aw_ok_q && w_ok_q && !bvalid_q;
    if (wr_fire)
    begin
      aw_ok_d = 1'b0;
      w_ok_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `SLC_RESP_OKAY;
      if (aw_q == `SLC_AXI_OFF_ADDR)
        addr_d = wd_q[11:0];
      else if (aw_q == `SLC_AXI_OFF_WDATA)
        wdat_d = wd_q[7:0];
      else if (aw_q == `SLC_AXI_OFF_CMD)
      begin
        // a command while busy is dropped; status busy tells software
        start = (st_q == SLC_H_IDLE) &&
          (wd_q[`SLC_CMD_WRITE] || wd_q[`SLC_CMD_READ]);
        start_we = wd_q[`SLC_CMD_WRITE];
      end
      else if (aw_q != `SLC_AXI_OFF_STATUS)
        bresp_d = `SLC_RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    // refuse unsafe writes rather than corrupt a live link
    guard_bad = start_we && (
      (shadow_en_q && (addr_q == `SLC_OFF_FRAMES || addr_q == `SLC_OFF_CTRL)) ||
      (addr_q == `SLC_OFF_CTRL && wdat_q[`SLC_BIT_UPPER] &&
        mi.lanes > `SLC_UPPER_LANE_LIMIT));
    if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = `SLC_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr == `SLC_AXI_OFF_ADDR)
        rdata_d = {20'h00000, addr_q};
      else if (s_axi_araddr == `SLC_AXI_OFF_WDATA)
        rdata_d = {24'h000000, wdat_q};
      else if (s_axi_araddr == `SLC_AXI_OFF_STATUS)
        rdata_d = {16'h0000, rd_q, 4'h0, ts_q, refused_q, done_q,
          st_q != SLC_H_IDLE};
      else if (s_axi_araddr != `SLC_AXI_OFF_CMD)
        rresp_d = `SLC_RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    case (st_q)
      SLC_H_IDLE:
      begin
        if (start)
        begin
          done_d = 1'b0;
          refused_d = guard_bad;
          if (guard_bad)
            done_d = 1'b1;
          else
          begin
            we_d = start_we;
            st_d = SLC_H_REQ;
          end
        end
      end
      SLC_H_REQ:
        st_d = SLC_H_WAIT;
      SLC_H_WAIT:
      begin
        if (link.reg_ack)
        begin
          st_d = SLC_H_IDLE;
          done_d = 1'b1;
          if (!we_q)
            rd_d = link.reg_rdata;
          else if (addr_q == `SLC_OFF_LINK_EN)
            shadow_en_d = wdat_q[`SLC_BIT_LINK_EN];
          else if (addr_q == `SLC_OFF_MODE)
            shadow_mode_d = wdat_q;
          else if (addr_q == `SLC_OFF_CTRL)
            ts_d = wdat_q[`SLC_SYNC_SEL_HI:`SLC_SYNC_SEL_LO] ==
              slc_pkg::SLC_SYNC_TIMESTAMP;
        end
      end
      default:
        st_d = SLC_H_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= SLC_H_IDLE;
      aw_q <= 4'h0;
      aw_ok_q <= 1'b0;
      wd_q <= 32'h0000_0000;
      w_ok_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      addr_q <= 12'h000;
      wdat_q <= 8'h00;
      we_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
      rd_q <= 8'h00;
      shadow_en_q <= 1'b1;
      shadow_mode_q <= `SLC_RST_MODE;
      ts_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      aw_q <= aw_d;
      aw_ok_q <= aw_ok_d;
      wd_q <= wd_d;
      w_ok_q <= w_ok_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      we_q <= we_d;
      done_q <= done_d;
      refused_q <= refused_d;
      rd_q <= rd_d;
      shadow_en_q <= shadow_en_d;
      shadow_mode_q <= shadow_mode_d;
      ts_q <= ts_d;
    end
  end

  assign s_axi_awready = !aw_ok_q;
  assign s_axi_wready = !w_ok_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign link.reg_req = (st_q == SLC_H_REQ);
  assign link.reg_we = we_q;
  assign link.reg_addr = addr_q;
  assign link.reg_wdata = wdat_q;
  assign timestamp_receiver_enable = ts_q;
endmodule
`default_nettype wire
